// ===== shared/dac_host_pkg.sv
/*
  constants for the quad serial converter host controller.
  assumes a 20 MHz system clock and an AXI4-Lite software port.
*/
package dac_host_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned WORD_BITS     = 16;
  localparam int unsigned CODE_BITS     = 12;
  localparam int unsigned ADDR_BITS     = 2;
  localparam int unsigned PAD_BITS      = 2;

  localparam int unsigned T_DS_NS   = 25;
  localparam int unsigned T_DH_NS   = 20;
  localparam int unsigned T_CH_NS   = 30;
  localparam int unsigned T_CL_NS   = 50;
  localparam int unsigned T_CSS_NS  = 55;
  localparam int unsigned T_CSH_NS  = 15;
  localparam int unsigned T_LD1_NS  = 40;
  localparam int unsigned T_LD2_NS  = 15;
  localparam int unsigned T_LDRW_NS = 45;
  localparam int unsigned T_LDDW_NS = 45;
  localparam int unsigned T_RSSH_NS = 25;
  localparam int unsigned T_RSTW_NS = 70;

  function automatic int unsigned min_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned CYC_CL   = min_cycles(T_CL_NS > T_DS_NS ?
                                                T_CL_NS : T_DS_NS);
  localparam int unsigned CYC_CH   = min_cycles(T_CH_NS > T_DH_NS ?
                                                T_CH_NS : T_DH_NS);
  localparam int unsigned CYC_CSS  = min_cycles(T_CSS_NS);
  localparam int unsigned CYC_CSH  = min_cycles(T_CSH_NS);
  localparam int unsigned CYC_LD1  = min_cycles(T_LD1_NS);
  localparam int unsigned CYC_LD2  = min_cycles(T_LD2_NS);
  localparam int unsigned CYC_LDRW = min_cycles(T_LDRW_NS);
  localparam int unsigned CYC_LDDW = min_cycles(T_LDDW_NS);
  localparam int unsigned CYC_RSSH = min_cycles(T_RSSH_NS);
  localparam int unsigned CYC_RSTW = min_cycles(T_RSTW_NS);

  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LAST   = 4'h8;

  localparam int unsigned CMD_CODE_LSB  = 0;
  localparam int unsigned CMD_CHAN_LSB  = 16;
  localparam int unsigned CMD_WRITE_BIT = 20;
  localparam int unsigned CMD_LOAD_BIT  = 21;
  localparam int unsigned CMD_ALL_BIT   = 22;
  localparam int unsigned CMD_CLEAR_BIT = 23;
  localparam int unsigned CMD_CSEL_BIT  = 24;
  localparam int unsigned CMD_HOLD_BIT  = 25;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    ST_IDLE, ST_LD_SETUP, ST_CS_SETUP, ST_CLK_LO, ST_CLK_HI,
    ST_CS_HOLD, ST_LD_GAP, ST_LD_PULSE, ST_ALL_PULSE,
    ST_SEL_SETUP, ST_CLR_PULSE
  } seq_state_e;
endpackage

// ===== src/axil_regs.sv
/*
  AXI4-Lite slave for the command, status and last-word registers.
  assumes one outstanding read and one outstanding write at a time.
*/
module axil_regs
  import dac_host_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      cmd_word,
  output logic             cmd_pulse,
  input  wire logic        cmd_accept,
  input  wire logic [31:0] status_word,
  input  wire logic [31:0] last_word
);
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic        w_full;
  wire         aw_take  = s_axi_awvalid && s_axi_awready;
  wire         w_take   = s_axi_wvalid && s_axi_wready;
  wire         both     = aw_held && w_held && !s_axi_bvalid;
  wire         hit_cmd  = (aw_addr == REG_CMD);
  wire         ar_take  = s_axi_arvalid && s_axi_arready;
  wire         rd_ok    = (s_axi_araddr == REG_CMD) ||
                          (s_axi_araddr == REG_STATUS) ||
                          (s_axi_araddr == REG_LAST);
  wire [31:0]  rd_mux   = (s_axi_araddr == REG_STATUS) ? status_word :
                          (s_axi_araddr == REG_LAST) ? last_word :
                          (s_axi_araddr == REG_CMD) ? cmd_word : 32'h0000_0000;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  // a command write waits here while the sequencer is busy
  assign w_full        = both && hit_cmd && !cmd_accept;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0000_0000;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (both && !w_full) begin
        aw_held <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end else if (both && !w_full) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      cmd_word     <= 32'h0000_0000;
      cmd_pulse    <= 1'b0;
    end else begin
      cmd_pulse <= both && hit_cmd && cmd_accept && (&s_axi_wstrb | 1'b1);
      if (both && !w_full) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= hit_cmd ? RESP_OKAY : RESP_SLVERR;
        if (hit_cmd) begin
          cmd_word <= w_data;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // axil_regs

// ===== src/cycle_timer.sv
/*
  loadable down counter that flags when its count has run out.
  assumes the loader is on the same clock.
*/
module cycle_timer
  import dac_host_pkg::*;
#(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  output logic                  done
);
  logic [WIDTH-1:0] remain;

  assign done = (remain == '0);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      remain <= '0;
    end else if (load) begin
      remain <= count;
    end else if (!done) begin
      remain <= remain - 1'b1;
    end
  end
endmodule // cycle_timer

// ===== src/dac_host.sv
/*
  host controller driving the serial, strobe and clear pins of a quad
  12-bit serial-input converter; software orders it over AXI4-Lite.
  assumes the converter pins are wired directly, with no other
  device sharing the serial clock or data line.
*/
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
module dac_host
  import dac_host_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             serial_in,
  output logic             serial_clk,
  output logic             chip_select_n,
  output logic             input_latch_strobe_n,
  output logic             output_latch_strobe_n,
  output logic             clear_n,
  output logic             clear_value_select
);
  seq_state_e  state;
  seq_state_e  next_state;
  logic [31:0] cmd_word;
  logic        cmd_pulse;
  logic [31:0] last_word;
  logic [15:0] shifter;
  logic [4:0]  bits_left;
  logic        do_load;
  logic        do_all;
  logic        clk_prev;
  logic [4:0]  rise_count;
  logic [31:0] done_count;
  logic        tload;
  logic [3:0]  tcount;
  logic        tdone;
  logic        idle;

  wire        is_write = cmd_word[CMD_WRITE_BIT];
  wire [15:0] frame    = {cmd_word[CMD_CHAN_LSB +: ADDR_BITS],
                          {PAD_BITS{1'b0}},
                          cmd_word[CMD_CODE_LSB +: CODE_BITS]};
  wire [31:0] status   = {done_count[15:0], 15'h0000, idle};

  assign idle = (state == ST_IDLE);

  axil_regs u_regs (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .cmd_word      (cmd_word),
    .cmd_pulse     (cmd_pulse),
    .cmd_accept    (idle),
    .status_word   (status),
    .last_word     (last_word)
  );

  cycle_timer #(.WIDTH(4)) u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .load    (tload),
    .count   (tcount),
    .done    (tdone)
  );

  // sequence: optional clear, optional shift, optional load, optional all
  always_comb begin
    next_state = state;
    tload      = 1'b0;
    tcount     = 4'h0;
    case (state)
      ST_IDLE: begin
        if (cmd_pulse) begin
          tload = 1'b1;
          if (cmd_word[CMD_CLEAR_BIT]) begin
            next_state = ST_SEL_SETUP;
            tcount     = 4'(CYC_RSSH);
          end else if (is_write) begin
            next_state = ST_LD_SETUP;
            tcount     = 4'(CYC_LD1);
          end else if (cmd_word[CMD_LOAD_BIT]) begin
            next_state = ST_LD_PULSE;
            tcount     = 4'(CYC_LDRW);
          end else if (cmd_word[CMD_ALL_BIT]) begin
            next_state = ST_ALL_PULSE;
            tcount     = 4'(CYC_LDDW);
          end
        end
      end
      ST_SEL_SETUP: if (tdone) begin
        next_state = ST_CLR_PULSE;
        tload      = 1'b1;
        tcount     = 4'(CYC_RSTW);
      end
      ST_CLR_PULSE: if (tdone) begin
        tload = 1'b1;
        if (do_load || is_write) begin
          next_state = ST_LD_SETUP;
          tcount     = 4'(CYC_LD1);
        end else if (do_all) begin
          next_state = ST_ALL_PULSE;
          tcount     = 4'(CYC_LDDW);
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_LD_SETUP: if (tdone) begin
        tload = 1'b1;
        if (is_write) begin
          next_state = ST_CS_SETUP;
          tcount     = 4'(CYC_CSS);
        end else begin
          next_state = ST_LD_PULSE;
          tcount     = 4'(CYC_LDRW);
        end
      end
      ST_CS_SETUP: if (tdone) begin
        next_state = ST_CLK_LO;
        tload      = 1'b1;
        tcount     = 4'(CYC_CL);
      end
      ST_CLK_LO: if (tdone) begin
        next_state = ST_CLK_HI;
        tload      = 1'b1;
        tcount     = 4'(CYC_CH);
      end
      ST_CLK_HI: if (tdone) begin
        tload = 1'b1;
        if (bits_left == 5'd1) begin
          next_state = ST_CS_HOLD;
          tcount     = 4'(CYC_CSH);
        end else begin
          next_state = ST_CLK_LO;
          tcount     = 4'(CYC_CL);
        end
      end
      ST_CS_HOLD: if (tdone) begin
        tload = 1'b1;
        if (do_load) begin
          next_state = ST_LD_GAP;
          tcount     = 4'(CYC_LD2);
        end else if (do_all) begin
          next_state = ST_ALL_PULSE;
          tcount     = 4'(CYC_LDDW);
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_LD_GAP: if (tdone) begin
        next_state = ST_LD_PULSE;
        tload      = 1'b1;
        tcount     = 4'(CYC_LDRW);
      end
      ST_LD_PULSE: if (tdone) begin
        tload = 1'b1;
        if (do_all) begin
          next_state = ST_ALL_PULSE;
          tcount     = 4'(CYC_LDDW);
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_ALL_PULSE: if (tdone) begin
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      do_load    <= 1'b0;
      do_all     <= 1'b0;
      shifter    <= 16'h0000;
      bits_left  <= 5'd0;
      last_word  <= 32'h0000_0000;
      done_count <= 32'h0000_0000;
    end else begin
      if (idle && cmd_pulse) begin
        do_load   <= cmd_word[CMD_LOAD_BIT];
        do_all    <= cmd_word[CMD_ALL_BIT];
        shifter   <= frame;
        bits_left <= 5'(WORD_BITS);
      end
      if (state == ST_CLK_HI && tdone) begin
        shifter   <= {shifter[14:0], 1'b0};
        bits_left <= bits_left - 5'd1;
      end
      if (state == ST_CS_HOLD && tdone) begin
        last_word <= {16'h0000, frame};
      end
      if (!idle && next_state == ST_IDLE) begin
        done_count <= done_count + 32'd1;
      end
    end
  end

  // pins come straight from flops; select stays high outside the frame
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serial_in             <= 1'b0;
      serial_clk            <= 1'b1;
      chip_select_n         <= 1'b1;
      input_latch_strobe_n  <= 1'b1;
      output_latch_strobe_n <= 1'b1;
      clear_n               <= 1'b1;
      clear_value_select    <= 1'b0;
    end else begin
      serial_in  <= shifter[15];
      // clock rises only in the high phase; select rises with clock high
      serial_clk <= (next_state != ST_CLK_LO);
      chip_select_n <= !(next_state == ST_CS_SETUP ||
                         next_state == ST_CLK_LO ||
                         next_state == ST_CLK_HI ||
                         next_state == ST_CS_HOLD);
      input_latch_strobe_n  <= (next_state != ST_LD_PULSE);
      output_latch_strobe_n <= (next_state != ST_ALL_PULSE);
      clear_n <= (next_state != ST_CLR_PULSE);
      if (state == ST_IDLE && cmd_pulse) begin
        clear_value_select <= cmd_word[CMD_CSEL_BIT];
      end
    end
  end

  // counts rises on the pin itself, apart from the bit counter
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_prev   <= 1'b1;
      rise_count <= 5'd0;
    end else begin
      clk_prev <= serial_clk;
      if (chip_select_n) begin
        rise_count <= 5'd0;
      end else if (serial_clk && !clk_prev) begin
        rise_count <= rise_count + 5'd1;
      end
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_ld_high_shift: assert property ($rose(serial_clk) |->
    input_latch_strobe_n && $past(input_latch_strobe_n))
    else $error("input strobe low while shifting");
  a_cs_rise_clk_hi: assert property ($rose(chip_select_n) |->
    serial_clk)
    else $error("select rose with clock low");
  a_ld_width: assert property ($fell(input_latch_strobe_n) |->
    (!input_latch_strobe_n)[*2])
    else $error("input strobe pulse short");
  a_all_width: assert property ($fell(output_latch_strobe_n) |=>
    !output_latch_strobe_n)
    else $error("output strobe pulse short");
  a_clr_width: assert property ($fell(clear_n) |->
    (!clear_n)[*2])
    else $error("clear pulse short");
  a_sel_setup: assert property ($fell(clear_n) |->
    $stable(clear_value_select))
    else $error("select changed at clear");
  a_cs_strobes: assert property (
    (!input_latch_strobe_n || !clear_n) |-> chip_select_n)
    else $error("select low during strobe");
  a_shift_count: assert property ((state == ST_CS_SETUP) |->
    bits_left == 5'd16)
    else $error("frame not sixteen bits");
  a_frame_rises: assert property ($rose(chip_select_n) |->
    rise_count == 5'(WORD_BITS))
    else $error("frame rise count wrong");
endmodule // dac_host

// ===== testbench/dac_dev_model.sv
/*
  behavioural model of the quad serial converter's digital side.
  assumes its pins come straight from the host; watch gates the
  timing checks so power-up transitions are not counted.
*/
module dac_dev_model
  import dac_host_pkg::*;
(
  input  wire logic   serial_in,
  input  wire logic   serial_clk,
  input  wire logic   chip_select_n,
  input  wire logic   input_latch_strobe_n,
  input  wire logic   output_latch_strobe_n,
  input  wire logic   clear_n,
  input  wire logic   clear_value_select,
  input  wire logic   watch,
  output logic [11:0] in_reg [4],
  output logic [11:0] out_reg [4],
  output int          faults
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sreg = 16'h0000;
  time         t_sh, t_ild, t_lo, t_olo, t_sel, t_clo;
  wire         shift_clk = chip_select_n | serial_clk;
  wire  [11:0] clr_val = clear_value_select ? 12'h800 : 12'h000;

  initial faults = 0;

  // clear has no path into the shift register
  always @(posedge shift_clk) begin
    sreg <= {sreg[14:0], serial_in};
    if (watch && (!input_latch_strobe_n || $time - t_ild < T_LD1_NS))
      faults++;
    t_sh = $time;
  end

  for (genvar i = 0; i < 4; i++) begin : g_ch
    // latches as in the part, so a slow strobe shows its full effect
    always @* begin
      if (!clear_n)
        in_reg[i] = clr_val;
      else if (!input_latch_strobe_n && output_latch_strobe_n &&
               sreg[15:14] == 2'(i))
        in_reg[i] = sreg[11:0];
    end
    always @* begin
      if (!clear_n)
        out_reg[i] = clr_val;
      else if (!output_latch_strobe_n && input_latch_strobe_n)
        out_reg[i] = in_reg[i];
    end
  end

  always @(negedge input_latch_strobe_n) begin
    if (watch && ($time - t_sh < T_LD2_NS || !chip_select_n))
      faults++;
    t_lo = $time;
  end
  always @(posedge input_latch_strobe_n) begin
    if (watch && $time - t_lo < T_LDRW_NS)
      faults++;
    t_ild = $time;
  end
  always @(negedge output_latch_strobe_n) t_olo = $time;
  always @(posedge output_latch_strobe_n)
    if (watch && $time - t_olo < T_LDDW_NS)
      faults++;
  always @(clear_value_select) t_sel = $time;
  always @(negedge clear_n) begin
    if (watch && ($time - t_sel < T_RSSH_NS || !chip_select_n))
      faults++;
    t_clo = $time;
  end
  always @(posedge clear_n)
    if (watch && $time - t_clo < T_RSTW_NS)
      faults++;
  always @(posedge chip_select_n)
    if (watch && serial_clk === 1'b0)
      faults++;
endmodule // dac_dev_model

// ===== testbench/quad_dac_serial_load_control_tb.sv
/*
  self-checking bench for dac_host with the converter model on its pins.
  assumes the register map and sequencing of the designer's note.
*/
module quad_dac_serial_load_control_tb
  import dac_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0, rst = 1'b1, watch = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        serial_in, serial_clk, chip_select_n, clear_n;
  logic        input_latch_strobe_n, output_latch_strobe_n;
  logic        clear_value_select;
  logic [11:0] in_reg [4];
  logic [11:0] out_reg [4];
  int          faults, errors = 0, n_checks = 0, cycles = 0;

  typedef struct {
    logic [31:0] cmd;
    logic [11:0] ein;
    logic [11:0] eout;
  } row_s;
  // channel checked is cmd[17:16]; rows run in order
  row_s rows [12] = '{
    '{32'h0180_0000, 12'h800, 12'h800},
    '{32'h0030_0123, 12'h123, 12'h800},
    '{32'h0031_0abc, 12'habc, 12'h800},
    '{32'h0032_0fff, 12'hfff, 12'h800},
    '{32'h0033_0001, 12'h001, 12'h800},
    '{32'h0043_0000, 12'h001, 12'h001},
    '{32'h0040_0000, 12'h123, 12'h123},
    '{32'h0071_0456, 12'h456, 12'h456},
    '{32'h0082_0000, 12'h000, 12'h000},
    '{32'h01b2_0321, 12'h321, 12'h800},
    '{32'h0052_0777, 12'h321, 12'h321},
    '{32'h00e2_0000, 12'h777, 12'h777}
  };

  dac_host dut (
    .sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .serial_in, .serial_clk,
    .chip_select_n, .input_latch_strobe_n, .output_latch_strobe_n,
    .clear_n, .clear_value_select
  );
  dac_dev_model dev (
    .serial_in, .serial_clk, .chip_select_n, .input_latch_strobe_n,
    .output_latch_strobe_n, .clear_n, .clear_value_select, .watch,
    .in_reg, .out_reg, .faults
  );

  always #25 sys_clk = ~sys_clk;

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("unexpected at %0t: timeout", $time);
      end_of_test();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask

  // ready is combinational: sampled at the falling edge, where it
  // already shows what the next rising edge will see
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic aw_t, w_t, b_t;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge sys_clk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid === 1'b1;
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ar_t, r_t;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge sys_clk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic send(input logic [31:0] c);
    logic [31:0] d;
    logic [1:0]  r;
    axw(REG_CMD, c, r);
    cmp(32'(r), 32'(RESP_OKAY), "cmd resp");
    d = 32'h0;
    while (d[0] !== 1'b1)
      axr(REG_STATUS, d, r);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [1:0]  ch;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    watch <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      ch = rows[i].cmd[17:16];
      send(rows[i].cmd);
      cmp(32'(in_reg[ch]), 32'(rows[i].ein), "in reg");
      cmp(32'(out_reg[ch]), 32'(rows[i].eout), "out reg");
      axr(REG_STATUS, d, r);
      cmp(32'(d[31:16]), i + 1, "done count");
      axr(REG_CMD, d, r);
      cmp(d, rows[i].cmd, "cmd readback");
      if (rows[i].cmd[20]) begin
        axr(REG_LAST, d, r);
        cmp(d, {16'h0, ch, 2'b00, rows[i].cmd[11:0]}, "frame");
      end
    end
    // shift alone, clear, then strobe alone: the held word survives
    send(32'h0012_0555);
    cmp(32'(in_reg[2]), 32'h777, "no strobe");
    send(32'h0180_0000);
    send(32'h0020_0000);
    cmp(32'(in_reg[2]), 32'h555, "held word");
    cmp(32'(in_reg[0]), 32'h800, "latched keeps");
    cmp(32'(out_reg[2]), 32'h800, "out held");
    // back-to-back orders: the second stalls until the first is done
    axw(REG_CMD, 32'h0033_0aaa, r);
    axw(REG_CMD, 32'h0030_0bbb, r);
    send(32'h0000_0000);
    cmp(32'(in_reg[3]), 32'haaa, "first of pair");
    cmp(32'(in_reg[0]), 32'hbbb, "second of pair");
    axw(REG_STATUS, 32'h0, r);
    cmp(32'(r), 32'(RESP_SLVERR), "ro write");
    axw(4'hc, 32'h0, r);
    cmp(32'(r), 32'(RESP_SLVERR), "unmapped write");
    axr(4'hc, d, r);
    cmp(32'(r), 32'(RESP_SLVERR), "unmapped read");
    cmp(d, 32'h0, "unmapped data");
    axr(REG_CMD, d, r);
    cmp(d, 32'h0, "cmd readback");
    cmp(32'(faults), 32'h0, "pin timing");
    cmp(32'(faults), 32'h0, "strobe timing");
    // second reset in mid-run
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    cmp(32'({serial_in, serial_clk, chip_select_n, input_latch_strobe_n,
             output_latch_strobe_n, clear_n, clear_value_select}),
        32'h3e, "reset pins");
    axr(REG_STATUS, d, r);
    cmp(d, 32'h1, "reset status");
    end_of_test();
  end
endmodule // quad_dac_serial_load_control_tb
